// ### hdl/wspc_pkg.sv
// Package for the watchdog, sleep and power control block.
// Assumes a single 25 MHz system clock and a synchronous active-high reset.
package wspc_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] WSPC_PWRCTL_IDX = 8'h8f;
  localparam logic [11:0] WSPC_PWRCTL_ADDR = {2'b00, WSPC_PWRCTL_IDX, 2'b00};
  localparam logic [11:0] WSPC_CTRL_ADDR = 12'h000;
  localparam logic [11:0] WSPC_STAT_ADDR = 12'h004;
  localparam logic [11:0] WSPC_WAKE_ADDR = 12'h008;

  // ****************************************
  // Power control fields
  // ****************************************
  localparam int unsigned WSPC_CONV_OFF_BIT = 0;
  localparam int unsigned WSPC_TEMP_OFF_BIT = 1;
  localparam int unsigned WSPC_CHG_OFF_BIT = 2;
  localparam int unsigned WSPC_OSC_GATE_BIT = 3;
  localparam int unsigned WSPC_BIAS_OFF_BIT = 4;
  localparam int unsigned WSPC_REF_OFF_BIT = 5;
  localparam int unsigned WSPC_DEEP_SEL_BIT = 7;
  localparam logic [7:0] WSPC_PWRCTL_RST = 8'h3f;
  localparam logic [7:0] WSPC_PWRCTL_MASK = 8'hbf;

  // ****************************************
  // Control register fields (command pulses and configuration bits)
  // ****************************************
  localparam int unsigned WSPC_CMD_CLR_BIT = 0;
  localparam int unsigned WSPC_CMD_SLEEP_BIT = 1;
  localparam int unsigned WSPC_CMD_RESTART_BIT = 2;
  localparam int unsigned WSPC_CFG_PSA_BIT = 8;
  localparam int unsigned WSPC_CFG_PS_LSB = 9;
  localparam int unsigned WSPC_GIE_BIT = 12;
  localparam int unsigned WSPC_NUM_WAKE = 8;
  localparam logic [WSPC_NUM_WAKE-1:0] WSPC_WAKE_EN_RST = 8'h00;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned WSPC_CLK_HZ = 25_000_000;
  localparam int unsigned WSPC_WDT_MS = 18;
  localparam int unsigned WSPC_WDT_CYC = WSPC_CLK_HZ / 1000 * WSPC_WDT_MS;
  localparam int unsigned WSPC_RC_DIV = 4;
  localparam logic [15:0] WSPC_IRQ_VECTOR = 16'h0004;
  localparam logic [15:0] WSPC_CAP_MAX = 16'hffff;

  typedef enum logic [1:0] {
    WSPC_RUN   = 2'b00,
    WSPC_SLEEP = 2'b01,
    WSPC_DEEP  = 2'b10
  } wspc_mode_t;

  typedef struct packed {
    logic temp_sensor_off;
    logic charge_detect_off;
    logic converter_off;
    logic bias_source_off;
    logic reference_off;
    logic main_osc_on;
    logic core_clk_en;
    logic capture_clk_en;
  } wspc_gate_t;

endpackage : wspc_pkg

// ### hdl/wspc_top.sv
// Watchdog timer, sleep and deep-sleep sequencing and analog power gating.
// Assumes AXI4-Lite master on sys_clk; wake sources are synchronous levels.
`timescale 1ns/1ps

// Summary of operation
// (R1) Watchdog counts on its own oscillator enable, also while core clock stops
// (R2) Time-out in run mode issues an internal full device reset
// (R3) Time-out in sleep wakes the core without reset
// (R4) Fuse low disables the watchdog permanently
// (R5) Watchdog reset never drives the external reset pin
// (R6) Base period 18 ms, optional prescaler up to 1:128
// (R7) Clear and sleep commands clear counter and assigned prescaler
// (R8) Every time-out clears the time-out flag
// (R9) Sleep entry clears power-down flag, sets time-out flag, clears watchdog
// (R10) Main oscillator in sleep runs only while gate bit is clear
// (R11) Power control bits gate the analog blocks
// (R12) Deep sleep is sleep with the watchdog forced off and all power gates forced off
// (R13) Capture clock stops on overflow until restart, gated by converter off
// (R14) Deep sleep powers off everything except regulator and power-on reset
// (R15) Listed wake events end sleep
// (R16) Software clears gate bits for converter or current-flow wake
// (R17) External reset in sleep resets; other wakes resume execution
// (R18) Enabled interrupts wake regardless of global enable
// (R19) After interrupt wake, next instruction runs, then vector if enabled
// (R20) Watchdog counter clears on every wake
// (R21) Pending enabled interrupt at sleep request keeps the core running; sleep is not entered
// (R22) Sleep with deep select bit set enters deep sleep; no watchdog wake
module wspc_top
  import wspc_pkg::*;
#(
  parameter int unsigned WDT_CYC = WSPC_WDT_CYC
) (
  input  wire logic                      sys_clk,
  input  wire logic                      rst,
  input  wire logic                      wdog_enable_fuse,
  input  wire logic                      ext_reset_n,
  input  wire logic [WSPC_NUM_WAKE-1:0]  wake_flags,
  input  wire logic                      capture_overflow,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [11:0]               s_axi_awaddr,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  output logic [1:0]                     s_axi_bresp,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  input  wire logic [11:0]               s_axi_araddr,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           core_reset,
  output logic                           ext_reset_oe,
  output logic                           ext_reset_out,
  output logic                           io_hold,
  output logic                           irq_vector_go,
  output logic [15:0]                    irq_vector_addr,
  output wspc_gate_t                     gates
);

  // ****************************************
  // Registers
  // ****************************************
  wspc_mode_t                   mode_q;
  logic [7:0]                   pwr_q;
  logic [WSPC_NUM_WAKE-1:0]     wake_en_q;
  logic                         psa_q;
  logic [2:0]                   ps_sel_q;
  logic                         gie_q;
  logic                         to_n_q;
  logic                         pd_n_q;
  logic                         cap_run_q;
  logic [31:0]                  wdt_cnt_q;
  logic [6:0]                   ps_cnt_q;
  logic [1:0]                   rc_div_q;
  logic                         core_rst_q;
  logic                         vec_q;
  logic                         aw_hold_q;
  logic                         w_hold_q;
  logic [11:0]                  aw_addr_q;
  logic [31:0]                  w_data_q;
  logic [3:0]                   w_strb_q;
  logic                         bvalid_q;
  logic                         rvalid_q;
  logic [31:0]                  rdata_q;
  logic                         rresp_err_q;
  logic                         bresp_err_q;

  // ****************************************
  // Bus decode
  // ****************************************
  wire        aw_ok     = s_axi_awvalid && !aw_hold_q && !bvalid_q;
  wire        w_ok      = s_axi_wvalid && !w_hold_q && !bvalid_q;
  wire        have_aw   = aw_hold_q || aw_ok;
  wire        have_w    = w_hold_q || w_ok;
  wire        wr_fire   = have_aw && have_w && !bvalid_q;
  wire [11:0] wr_addr   = aw_hold_q ? aw_addr_q : s_axi_awaddr;
  wire [31:0] wr_data   = w_hold_q ? w_data_q : s_axi_wdata;
  wire [3:0]  wr_strb   = w_hold_q ? w_strb_q : s_axi_wstrb;
  wire        wr_pwr    = wr_fire && wr_addr == WSPC_PWRCTL_ADDR;
  wire        wr_ctrl   = wr_fire && wr_addr == WSPC_CTRL_ADDR;
  wire        wr_wake   = wr_fire && wr_addr == WSPC_WAKE_ADDR;
  wire        wr_hit    = wr_pwr || wr_ctrl || wr_wake;
  wire        rd_fire   = s_axi_arvalid && !rvalid_q;
  wire        cmd_clr   = wr_ctrl && wr_strb[0] && wr_data[WSPC_CMD_CLR_BIT];
  wire        cmd_sleep = wr_ctrl && wr_strb[0] && wr_data[WSPC_CMD_SLEEP_BIT];
  wire        cmd_rst   = wr_ctrl && wr_strb[0] && wr_data[WSPC_CMD_RESTART_BIT];
  wire        cfg_wr    = wr_ctrl && wr_strb[1];

  assign s_axi_awready = aw_ok;
  assign s_axi_wready  = w_ok;
  assign s_axi_arready = rd_fire;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_err_q ? 2'b10 : 2'b00;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_err_q ? 2'b10 : 2'b00;

  wire [31:0] rd_ctrl = {19'h0, gie_q, ps_sel_q, psa_q, 8'h00};
  wire [31:0] rd_stat = {28'h0, mode_q, pd_n_q, to_n_q};
  wire [31:0] rd_mux  = (s_axi_araddr == WSPC_PWRCTL_ADDR) ? {24'h0, pwr_q}
                      : (s_axi_araddr == WSPC_CTRL_ADDR)   ? rd_ctrl
                      : (s_axi_araddr == WSPC_STAT_ADDR)   ? rd_stat
                      : (s_axi_araddr == WSPC_WAKE_ADDR)   ? {24'h0, wake_en_q}
                      : 32'h0000_0000;
  wire        rd_hit  = s_axi_araddr == WSPC_PWRCTL_ADDR || s_axi_araddr == WSPC_CTRL_ADDR
                     || s_axi_araddr == WSPC_STAT_ADDR || s_axi_araddr == WSPC_WAKE_ADDR;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      aw_hold_q   <= 1'b0;
      w_hold_q    <= 1'b0;
      aw_addr_q   <= 12'h000;
      w_data_q    <= 32'h0000_0000;
      w_strb_q    <= 4'h0;
      bvalid_q    <= 1'b0;
      bresp_err_q <= 1'b0;
      rvalid_q    <= 1'b0;
      rdata_q     <= 32'h0000_0000;
      rresp_err_q <= 1'b0;
    end else begin
      aw_hold_q <= have_aw && !wr_fire;
      w_hold_q  <= have_w && !wr_fire;
      if (aw_ok) begin
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_ok) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        bvalid_q    <= 1'b1;
        bresp_err_q <= !wr_hit;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
      if (rd_fire) begin
        rvalid_q    <= 1'b1;
        rdata_q     <= rd_mux;
        rresp_err_q <= !rd_hit;
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // Watchdog
  // ****************************************
  wire       asleep    = mode_q != WSPC_RUN;
  wire       wdt_on    = wdog_enable_fuse && mode_q != WSPC_DEEP;   // see (R4) see (R12)
  wire       rc_tick   = rc_div_q == 2'(WSPC_RC_DIV - 1);          // see (R1)
  wire [6:0] ps_last   = 7'((1 << ps_sel_q) - 1);                   // see (R6)
  wire       ps_tick   = !psa_q || ps_cnt_q >= ps_last;
  wire       wdt_timeout = wdt_on && rc_tick && ps_tick
                        && wdt_cnt_q >= 32'(WDT_CYC / WSPC_RC_DIV - 1);
  wire [WSPC_NUM_WAKE-1:0] pend = wake_flags & wake_en_q;
  wire       irq_wake  = |pend;                                     // see (R18)
  wire       ext_rst   = !ext_reset_n;
  wire       wake      = asleep && (irq_wake || wdt_timeout);      // see (R15)
  wire       clr_wdt   = cmd_clr || cmd_sleep || wake;              // see (R7) see (R20)

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rc_div_q  <= 2'b00;
      wdt_cnt_q <= 32'h0000_0000;
      ps_cnt_q  <= 7'h00;
    end else begin
      rc_div_q <= rc_tick ? 2'b00 : rc_div_q + 2'b01;
      if (clr_wdt || ext_rst || !wdt_on || wdt_timeout) begin
        wdt_cnt_q <= 32'h0000_0000;
        ps_cnt_q  <= 7'h00;                                         // see (R7)
      end else if (rc_tick) begin
        ps_cnt_q <= ps_tick ? 7'h00 : ps_cnt_q + 7'h01;
        if (ps_tick) begin
          wdt_cnt_q <= wdt_cnt_q + 32'h0000_0001;
        end
      end
    end
  end

  // ****************************************
  // Mode sequencing and flags
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (rst || ext_rst) begin                                       // see (R17)
      mode_q     <= WSPC_RUN;
      pwr_q      <= WSPC_PWRCTL_RST;
      wake_en_q  <= WSPC_WAKE_EN_RST;
      psa_q      <= 1'b0;
      ps_sel_q   <= 3'b000;
      gie_q      <= 1'b0;
      to_n_q     <= 1'b1;
      pd_n_q     <= 1'b1;
      cap_run_q  <= 1'b1;
      core_rst_q <= 1'b0;
      vec_q      <= 1'b0;
    end else begin
      core_rst_q <= wdt_timeout && !asleep;                         // see (R2)
      vec_q      <= 1'b0;
      if (wr_pwr && wr_strb[0]) begin
        pwr_q <= wr_data[7:0] & WSPC_PWRCTL_MASK;                   // see (R11)
      end
      if (wr_wake && wr_strb[0]) begin
        wake_en_q <= wr_data[WSPC_NUM_WAKE-1:0];
      end
      if (cfg_wr) begin
        psa_q    <= wr_data[WSPC_CFG_PSA_BIT];
        ps_sel_q <= wr_data[WSPC_CFG_PS_LSB +: 3];
        gie_q    <= wr_data[WSPC_GIE_BIT];
      end
      if (capture_overflow) begin
        cap_run_q <= 1'b0;                                          // see (R13)
      end else if (cmd_rst) begin
        cap_run_q <= 1'b1;
      end
      case (mode_q)
        WSPC_RUN: begin
          if (cmd_sleep && !irq_wake) begin                         // see (R21)
            mode_q <= pwr_q[WSPC_DEEP_SEL_BIT] ? WSPC_DEEP : WSPC_SLEEP;  // see (R22)
            pd_n_q <= 1'b0;                                         // see (R9)
            to_n_q <= 1'b1;
          end
        end
        WSPC_SLEEP, WSPC_DEEP: begin
          if (wake) begin
            mode_q <= WSPC_RUN;                                     // see (R3)
            vec_q  <= irq_wake && gie_q;                            // see (R19)
          end
        end
        default: mode_q <= WSPC_RUN;
      endcase
      if (wdt_timeout) begin
        to_n_q <= 1'b0;                                             // see (R8)
      end
    end
  end

  // ****************************************
  // Outputs and power gating
  // ****************************************
  wire deep = mode_q == WSPC_DEEP;                                  // see (R14)

  assign core_reset      = core_rst_q;
  assign ext_reset_oe    = 1'b0;                                    // see (R5)
  assign ext_reset_out   = 1'b0;
  assign io_hold         = asleep;                                  // see (R9)
  assign irq_vector_go   = vec_q;
  assign irq_vector_addr = WSPC_IRQ_VECTOR;
  assign gates.temp_sensor_off   = deep || pwr_q[WSPC_TEMP_OFF_BIT];   // see (R11)
  assign gates.charge_detect_off = deep || pwr_q[WSPC_CHG_OFF_BIT];
  assign gates.converter_off     = deep || pwr_q[WSPC_CONV_OFF_BIT];
  assign gates.bias_source_off   = deep || pwr_q[WSPC_BIAS_OFF_BIT];
  assign gates.reference_off     = deep || pwr_q[WSPC_REF_OFF_BIT];
  assign gates.main_osc_on       = !asleep || (!deep && !pwr_q[WSPC_OSC_GATE_BIT]);  // see (R10)
  assign gates.core_clk_en       = !asleep;
  assign gates.capture_clk_en    = cap_run_q && !gates.converter_off
                                && gates.main_osc_on;               // see (R13)

  // ****************************************
  // Checks
  // ****************************************
  chk_run_timeout_reset: assert property (@(posedge sys_clk) disable iff (rst) // see (R2)
    (wdt_timeout && mode_q == WSPC_RUN && ext_reset_n) |=> core_reset)
    else $error("run time-out gave no reset");

  chk_sleep_timeout_wake: assert property (@(posedge sys_clk) disable iff (rst) // see (R3)
    (wdt_timeout && mode_q == WSPC_SLEEP && ext_reset_n) |=> mode_q == WSPC_RUN && !core_reset)
    else $error("sleep time-out did not wake cleanly");

  chk_fuse_off_quiet: assert property (@(posedge sys_clk) disable iff (rst) // see (R4)
    !wdog_enable_fuse |-> !wdt_timeout)
    else $error("watchdog fired with fuse off");

  chk_pin_never_driven: assert property (@(posedge sys_clk) disable iff (rst) // see (R5)
    !ext_reset_oe)
    else $error("reset pin driven");

  chk_timeout_flag: assert property (@(posedge sys_clk) disable iff (rst) // see (R8)
    (wdt_timeout && ext_reset_n) |=> !to_n_q)
    else $error("time-out flag not cleared");

  chk_sleep_entry: assert property (@(posedge sys_clk) disable iff (rst) // see (R9)
    (mode_q == WSPC_RUN ##1 mode_q != WSPC_RUN)
    |-> !pd_n_q && io_hold && wdt_cnt_q == 32'h0000_0000)
    else $error("sleep entry flags wrong");

  chk_sleep_osc_gate: assert property (@(posedge sys_clk) disable iff (rst) // see (R10)
    (mode_q == WSPC_SLEEP) |-> !gates.core_clk_en && gates.main_osc_on == !pwr_q[WSPC_OSC_GATE_BIT])
    else $error("sleep clock gating wrong");

  chk_deep_no_wdt: assert property (@(posedge sys_clk) disable iff (rst) // see (R12)
    deep |-> !wdt_timeout && gates.reference_off && !gates.main_osc_on)
    else $error("deep sleep not fully off");

  chk_capture_stop: assert property (@(posedge sys_clk) disable iff (rst) // see (R13)
    (capture_overflow && ext_reset_n) |=> !gates.capture_clk_en)
    else $error("capture clock ran after overflow");

  chk_ext_reset_run: assert property (@(posedge sys_clk) disable iff (rst) // see (R17)
    !ext_reset_n |=> mode_q == WSPC_RUN && pwr_q == WSPC_PWRCTL_RST && !core_reset)
    else $error("external reset did not reset");

  chk_irq_wake_exit: assert property (@(posedge sys_clk) disable iff (rst) // see (R18)
    (asleep && irq_wake && ext_reset_n) |=> !asleep)
    else $error("enabled interrupt did not wake");

  chk_vector_on_gie: assert property (@(posedge sys_clk) disable iff (rst) // see (R19)
    (wake && irq_wake && gie_q && ext_reset_n) |=> irq_vector_go)
    else $error("no vector after interrupt wake");

  chk_wake_clears_wdt: assert property (@(posedge sys_clk) disable iff (rst) // see (R20)
    (wake && ext_reset_n) |=> wdt_cnt_q == 32'h0000_0000 && !asleep)
    else $error("wake left watchdog running");

  chk_pending_no_sleep: assert property (@(posedge sys_clk) disable iff (rst) // see (R21)
    (mode_q == WSPC_RUN && cmd_sleep && irq_wake) |=> mode_q == WSPC_RUN)
    else $error("slept with pending interrupt");

  chk_deep_entry: assert property (@(posedge sys_clk) disable iff (rst) // see (R22)
    (mode_q == WSPC_RUN && cmd_sleep && !irq_wake && pwr_q[WSPC_DEEP_SEL_BIT] && ext_reset_n)
    |=> deep)
    else $error("deep select did not enter deep sleep");

  cov_sleep_irq_wake: cover property (@(posedge sys_clk) disable iff (rst)
    mode_q == WSPC_SLEEP ##1 irq_vector_go);
  cov_deep_wake: cover property (@(posedge sys_clk) disable iff (rst)
    deep ##1 mode_q == WSPC_RUN);
  cov_run_reset: cover property (@(posedge sys_clk) disable iff (rst) core_reset);
  cov_deep_entry: cover property (@(posedge sys_clk) disable iff (rst)
    mode_q == WSPC_RUN ##1 deep);
  cov_pending_refused: cover property (@(posedge sys_clk) disable iff (rst)
    mode_q == WSPC_RUN && cmd_sleep && irq_wake);

endmodule : wspc_top

// ### bench/tb.sv
// Self-checking bench for the watchdog, sleep and power control block.
// Assumes wspc_pkg and wspc_top are compiled first; the bench is the bus master.
`timescale 1ns/1ps
module tb;
  import wspc_pkg::*;
  // ****************************************
  // Signals and instance
  // ****************************************
  localparam int unsigned WCYC = 64;
  logic        sys_clk, rst, fuse, ext_n, cap_ovf;
  logic [7:0]  flags, p;
  logic        awv, awr, wv, wr, bv, br, arv, arr, rv, rr, g;
  logic [11:0] awa, ara;
  logic [31:0] wd, rdat, rd;
  logic [3:0]  ws;
  logic [1:0]  bresp, rresp, resp;
  logic        core_rst, oe, eout, hold, vgo;
  logic [15:0] vaddr;
  wspc_gate_t  gates;
  int          n_fail, checks_done, cyc, n_rst, n_vec, seed, t, i, k, b, n;

  wspc_top #(.WDT_CYC(WCYC)) i_wspc_top (
    .sys_clk(sys_clk), .rst(rst), .wdog_enable_fuse(fuse), .ext_reset_n(ext_n),
    .wake_flags(flags), .capture_overflow(cap_ovf),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
    .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
    .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rdat), .s_axi_rresp(rresp),
    .core_reset(core_rst), .ext_reset_oe(oe), .ext_reset_out(eout), .io_hold(hold),
    .irq_vector_go(vgo), .irq_vector_addr(vaddr), .gates(gates)
  );

  // ****************************************
  // Clock, pulse monitors, time limit
  // ****************************************
  initial begin
    sys_clk = 0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(negedge sys_clk) begin
    if (core_rst === 1'h1) n_rst++;
    if (vgo === 1'h1) n_vec++;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc >= 60000) begin
      n_fail++;
      close_out();
    end
  end

  // ****************************************
  // Tasks and functions
  // ****************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic chk_rng(input string what, input int v, input int lo, input int hi);
    chk(what, 32'h0000_0001, {31'h0, v >= lo && v <= hi});
  endtask : chk_rng

  task automatic close_out();
    if (n_fail == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    logic ad, dd, an, dn;
    ad = 0;
    dd = 0;
    @(posedge sys_clk);
    awa <= a; wd <= d; ws <= s; awv <= 1; wv <= 1; br <= 1;
    while (!(ad && dd)) begin
      @(negedge sys_clk);
      an = !ad && awr === 1'h1;
      dn = !dd && wr === 1'h1;
      @(posedge sys_clk);
      if (an) awv <= 0;
      if (dn) wv <= 0;
      ad = ad | an;
      dd = dd | dn;
    end
    do begin
      @(negedge sys_clk);
      an = bv === 1'h1;
      resp = bresp;
      @(posedge sys_clk);
    end while (!an);
    br <= 0;
  endtask : wr_reg

  task automatic rd_reg(input logic [11:0] a);
    logic an;
    an = 0;
    @(posedge sys_clk);
    ara <= a; arv <= 1; rr <= 1;
    while (!an) begin
      @(negedge sys_clk);
      an = arr === 1'h1;
      @(posedge sys_clk);
    end
    arv <= 0;
    do begin
      @(negedge sys_clk);
      an = rv === 1'h1;
      rd = rdat;
      resp = rresp;
      @(posedge sys_clk);
    end while (!an);
    rr <= 0;
  endtask : rd_reg

  task automatic wait_hold(input logic v, input int lim);
    k = 0;
    while (hold !== v && k < lim) begin
      @(negedge sys_clk);
      k++;
    end
    chk("io_hold", {31'h0, v}, {31'h0, hold});
  endtask : wait_hold

  task automatic wdt_time(output int w);
    int s0;
    s0 = n_rst;
    w = 0;
    while (n_rst == s0 && w < 5000) begin
      @(negedge sys_clk);
      w++;
    end
  endtask : wdt_time

  task automatic set_flags(input logic [7:0] f);
    @(posedge sys_clk);
    flags <= f;
  endtask : set_flags

  function automatic logic [31:0] stat(input logic ton, input logic pdn, input logic [1:0] m);
    return {28'h000_0000, m, pdn, ton};
  endfunction : stat

  function automatic logic [7:0] run_gates(input logic [7:0] q);
    return {q[1], q[2], q[0], q[4], q[5], 3'h6};
  endfunction : run_gates

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    seed = 12; rst = 1; fuse = 0; ext_n = 1; flags = 0; cap_ovf = 0;
    awv = 0; wv = 0; br = 0; arv = 0; rr = 0; awa = 0; ara = 0; wd = 0; ws = 0;
    repeat (16) @(posedge sys_clk);
    rst <= 0;
    // Reset state and unmapped places
    rd_reg(WSPC_PWRCTL_ADDR); chk("pwr", 32'h0000_003f, rd);
    rd_reg(WSPC_STAT_ADDR); chk("stat", stat(1, 1, 0), rd);
    chk("gates", run_gates(8'h3f), gates);
    rd_reg(12'h100); chk("rresp", 32'h0000_0002, resp); chk("rdata", 0, rd);
    wr_reg(12'h104, 32'h0000_00ff, 4'hf); chk("bresp", 32'h0000_0002, resp);
    // Analog gating from random power values
    repeat (6) begin
      p = $random(seed) & 8'h3f;
      wr_reg(WSPC_PWRCTL_ADDR, {24'h0, p | 8'h40}, 4'h1);
      rd_reg(WSPC_PWRCTL_ADDR); chk("pwr", {24'h0, p}, rd);
      chk("gates", run_gates(p) | {7'h00, !p[0]}, gates);
    end
    // Capture clock stop and restart
    wr_reg(WSPC_PWRCTL_ADDR, 32'h0000_003e, 4'h1);
    wr_reg(WSPC_CTRL_ADDR, 32'h0000_0004, 4'h1);
    @(negedge sys_clk); chk("cap_clk", 1, gates.capture_clk_en);
    @(posedge sys_clk) cap_ovf <= 1;
    @(posedge sys_clk) cap_ovf <= 0;
    repeat (5) @(negedge sys_clk);
    chk("cap_clk", 0, gates.capture_clk_en);
    wr_reg(WSPC_CTRL_ADDR, 32'h0000_0004, 4'h1);
    @(negedge sys_clk); chk("cap_clk", 1, gates.capture_clk_en);
    wr_reg(WSPC_PWRCTL_ADDR, 32'h0000_003f, 4'h1);
    @(negedge sys_clk); chk("cap_clk", 0, gates.capture_clk_en);
    // Fuse low keeps the watchdog quiet
    b = n_rst; repeat (4 * WCYC) @(posedge sys_clk);
    chk("wdt_resets", b, n_rst);
    // Watchdog period in run, with and without prescaler
    fuse <= 1;
    wr_reg(WSPC_CTRL_ADDR, 32'h0000_0001, 4'h3);
    wdt_time(t); chk_rng("wdt_period", t, WCYC - 8, WCYC + 8);
    chk("pin_oe", 0, oe); chk("pin_out", 0, eout);
    n = ($unsigned($random(seed)) % 3) + 1;
    wr_reg(WSPC_CTRL_ADDR, 32'h0000_0101 | (n << 9), 4'h3);
    wdt_time(t); chk_rng("wdt_scaled", t, (WCYC << n) - 8, (WCYC << n) + 8);
    b = n_rst;
    repeat (8) begin
      repeat (WCYC / 2) @(posedge sys_clk);
      wr_reg(WSPC_CTRL_ADDR, 32'h0000_0001, 4'h3);
    end
    chk("wdt_cleared", b, n_rst);
    // Watchdog wake from sleep
    wr_reg(WSPC_PWRCTL_ADDR, 32'h0000_0037, 4'h1);
    b = n_rst;
    wr_reg(WSPC_CTRL_ADDR, 32'h0000_0002, 4'h1);
    @(negedge sys_clk); chk("sleep_osc", 1, gates.main_osc_on);
    chk("sleep_hold", 1, hold);
    wait_hold(0, 5000);
    chk("wake_no_reset", b, n_rst);
    rd_reg(WSPC_STAT_ADDR); chk("stat", stat(0, 0, 0), rd);
    wdt_time(t); chk_rng("wdt_after_wake", t, WCYC - 16, WCYC + 8);
    fuse <= 0;
    // Interrupt wake per source, sources 0 to 6
    for (i = 0; i < 7; i++) begin
      g = $random(seed);
      p = $random(seed) & 8'h3f;
      if (i == 4) p[2] = 1'b0;
      if (i >= 5) p[3] = 1'b0;
      b = n_vec;
      wr_reg(WSPC_PWRCTL_ADDR, {24'h0, p}, 4'h1);
      wr_reg(WSPC_WAKE_ADDR, 32'h0000_0001 << i, 4'h1);
      wr_reg(WSPC_CTRL_ADDR, {19'h0, g, 12'h002}, 4'h3);
      @(negedge sys_clk); chk("sleep_osc", !p[3], gates.main_osc_on);
      chk("core_clk", 0, gates.core_clk_en);
      set_flags(8'h01 << ((i + 1) % 7));
      repeat (20) @(posedge sys_clk);
      chk("masked_wake", 1, hold);
      set_flags(8'h01 << i);
      wait_hold(0, 50);
      set_flags(8'h00);
      rd_reg(WSPC_STAT_ADDR); chk("stat", stat(1, 0, 0), rd);
      chk("vector_go", b + g, n_vec); chk("vector", 16'h0004, vaddr);
    end
    // Pending enabled flag at sleep request
    wr_reg(WSPC_WAKE_ADDR, 32'h0000_0001, 4'h1);
    set_flags(8'h01);
    wr_reg(WSPC_CTRL_ADDR, 32'h0000_0002, 4'h3);
    repeat (10) @(negedge sys_clk);
    chk("pending_wake", 0, hold);
    set_flags(8'h00);
    // Deep sleep: watchdog off, all gated
    fuse <= 1;
    wr_reg(WSPC_CTRL_ADDR, 32'h0000_0001, 4'h3);
    p = 8'h80 | ($random(seed) & 8'h3f);
    wr_reg(WSPC_PWRCTL_ADDR, {24'h0, p}, 4'h1);
    b = n_rst;
    wr_reg(WSPC_CTRL_ADDR, 32'h0000_0002, 4'h3);
    @(negedge sys_clk); chk("deep_gates", 8'hf8, gates);
    repeat (4 * WCYC) @(posedge sys_clk);
    chk("deep_hold", 1, hold); chk("deep_wdt", b, n_rst);
    rd_reg(WSPC_STAT_ADDR); chk("stat", stat(1, 0, 2), rd);
    fuse <= 0;
    wr_reg(WSPC_WAKE_ADDR, 32'h0000_0004, 4'h1);
    set_flags(8'h04);
    wait_hold(0, 50);
    set_flags(8'h00);
    // External reset during sleep
    wr_reg(WSPC_CTRL_ADDR, 32'h0000_0002, 4'h3);
    @(posedge sys_clk) ext_n <= 0;
    repeat (3) @(posedge sys_clk);
    ext_n <= 1;
    wait_hold(0, 4);
    rd_reg(WSPC_PWRCTL_ADDR); chk("pwr", 32'h0000_003f, rd);
    rd_reg(WSPC_WAKE_ADDR); chk("wake_en", 0, rd);
    rd_reg(WSPC_STAT_ADDR); chk("mode", 0, rd & 32'h0000_000c);
    close_out();
  end
endmodule : tb
